// File: pkg/fsx_pkg.sv
// Constants and helpers shared by the flag-expansion FIFO design
package fsx_pkg;

	// Data path and offset widths
	localparam int          DATA_W        = 18;
	localparam int          OFS_W         = 12;
	localparam int          DEF_DEPTH     = 256;

	// Default offsets per depth
	localparam int          DEF_OFS_256   = 31;
	localparam int          DEF_OFS_512   = 63;
	localparam int          DEF_OFS_LARGE = 127;

	// APB register byte offsets
	localparam logic [11:0] CTRL_ADDR     = 12'h000;
	localparam logic [11:0] EOFS_ADDR     = 12'h004;
	localparam logic [11:0] FOFS_ADDR     = 12'h008;
	localparam logic [11:0] STAT_ADDR     = 12'h00C;
	localparam logic [11:0] COUNT_ADDR    = 12'h010;

	// CTRL fields
	localparam int          CTRL_FLUSH    = 0;
	localparam int          CTRL_WR_HOLD  = 1;

	// STAT fields
	localparam int          STAT_FULL_N   = 0;
	localparam int          STAT_EMPTY_N  = 1;
	localparam int          STAT_HALF_N   = 2;
	localparam int          STAT_AFULL_N  = 3;
	localparam int          STAT_AEMPTY_N = 4;
	localparam int          STAT_DEPTH_MD = 5;
	localparam int          STAT_WR_TOKEN = 6;
	localparam int          STAT_RD_TOKEN = 7;

	// Offset used when software and pins never program one
	function automatic logic [OFS_W-1:0] fsx_default_offset(input int depth);
		if (depth == 256)
			return OFS_W'(DEF_OFS_256);
		else if (depth == 512)
			return OFS_W'(DEF_OFS_512);
		else
			return OFS_W'(DEF_OFS_LARGE);
	endfunction : fsx_default_offset

endpackage : fsx_pkg

// File: hw/fsx_fifo.sv
// Flag-rich FIFO with offset registers, depth-expansion chain and APB port
//
// Contract
// - Chain inputs tied low mean standalone mode
// - Full flag low after depth writes
// - Full blocks writes, updates on write edge
// - Empty flag low when pointers equal
// - Half-full low above half depth in standalone mode
// - Almost-full low at depth minus m
// - Default offsets 31, 63 or 127
// - Almost-full set on write, cleared on read
// - Almost-empty low at n words or fewer
// - Almost-empty set on read, cleared on write
// - Write chain pulse on last-location write
// - Read chain pulse on last-location read
// - Read data is 18 bits wide
// - Data low after reset when enabled
// - Clocks may run during reset
// - Full releases in current cycle
// - Empty releases in current cycle
// - First word follows empty flag release
// - Reset clears pointers and presets flags
// - Offset load alternates empty then full
// - Ignore write when full, read when empty
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module fsx_fifo
	import fsx_pkg::*;
#(
	parameter int DEPTH = DEF_DEPTH
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rstn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Write side
	input  wire logic              write_en_n,
	input  wire logic [DATA_W-1:0] write_data,
	input  wire logic              offset_load_n,
	input  wire logic              first_in_chain_n,
	input  wire logic              write_chain_in_n,
	input  wire logic              read_chain_in_n,
	// Read side
	input  wire logic              read_en_n,
	input  wire logic              output_en_n,
	output logic      [DATA_W-1:0] read_data_out,
	output logic                   read_data_oe,
	// Flags and chain outputs
	output logic                   full_flag_n,
	output logic                   empty_flag_n,
	output logic                   half_full_flag_n,
	output logic                   almost_full_flag_n,
	output logic                   almost_empty_flag_n,
	output logic                   read_chain_out_n
);

	localparam int              AW      = $clog2(DEPTH);
	localparam logic [AW:0]     DEPTH_C = (AW+1)'(DEPTH);
	localparam logic [AW:0]     HALF_C  = (AW+1)'(DEPTH / 2);
	localparam logic [AW-1:0]   LAST_C  = AW'(DEPTH - 1);
	localparam logic [OFS_W-1:0] OFS_DEF = fsx_default_offset(DEPTH);

	logic [DATA_W-1:0] mem_reg [DEPTH];     // Storage array
	logic [AW:0]       wr_ptr_reg;          // Write pointer, wrap bit on top
	logic [AW:0]       rd_ptr_reg;          // Read pointer, wrap bit on top
	logic [AW:0]       count;               // Words stored now
	logic [AW:0]       count_next;          // Words stored after this edge
	logic [OFS_W-1:0]  empty_ofs_reg;       // Offset n
	logic [OFS_W-1:0]  full_ofs_reg;        // Offset m
	logic              ld_wsel_reg;         // Pin load selector, 1 = full
	logic              ld_rsel_reg;         // Pin readback selector
	logic              depth_mode_reg;      // Chain in use
	logic              wr_token_reg;        // This device owns writes
	logic              rd_token_reg;        // This device owns reads
	logic              wr_chain_reg;        // Write chain pulse, active high
	logic              flush_reg;           // Software flush pulse
	logic              wr_hold_reg;         // Software write stall
	logic              wr_ok;               // Write accepted this edge
	logic              rd_ok;               // Read accepted this edge
	logic              apb_done;            // APB access completes
	logic [13:0]       cnt_plus_m;          // Count plus m, no overflow

	// Accept only when not full / not empty, enabled and owning the token
	assign wr_ok = offset_load_n && !write_en_n && full_flag_n &&
		wr_token_reg && !wr_hold_reg;
	assign rd_ok = offset_load_n && !read_en_n && empty_flag_n &&
		rd_token_reg;
	assign apb_done = psel && penable && pready;

	// Occupancy from the pointer difference, one clock so no resync needed
	assign count      = wr_ptr_reg - rd_ptr_reg;
	assign count_next = flush_reg ? '0 :
		count + (AW+1)'(wr_ok) - (AW+1)'(rd_ok);
	assign cnt_plus_m = 14'(count_next) + 14'(full_ofs_reg);

	// Storage write, no reset needed on the array
	always_ff @(posedge clock) begin
		if (wr_ok) begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= write_data;
		end
	end

	// Pointers; reset and flush return both to the first location
	always_ff @(posedge clock) begin
		if (!rstn || flush_reg) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (wr_ok)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (rd_ok)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end

	// Flags track the post-edge count, so release happens at once
	always_ff @(posedge clock) begin
		if (!rstn) begin
			full_flag_n         <= 1'b1;
			empty_flag_n        <= 1'b0;
			almost_full_flag_n  <= 1'b1;
			almost_empty_flag_n <= 1'b0;
		end else begin
			full_flag_n  <= count_next != DEPTH_C;
			empty_flag_n <= count_next != '0;
			// Write raises count, read lowers it: both edges move it
			almost_full_flag_n <= cnt_plus_m < 14'(DEPTH_C);
			almost_empty_flag_n <=
				13'(count_next) > 13'(empty_ofs_reg);
		end
	end

	// Shared pin: half-full standalone, write chain pulse in depth mode
	always_ff @(posedge clock) begin
		if (!rstn)
			half_full_flag_n <= 1'b1;
		else if (depth_mode_reg)
			half_full_flag_n <= !wr_chain_reg;
		else
			half_full_flag_n <= count_next <= HALF_C;
	end

	// Mode caught while reset is held; tied-low chain inputs mean standalone
	always_ff @(posedge clock) begin
		if (!rstn)
			depth_mode_reg <= write_chain_in_n || read_chain_in_n;
	end

	// Write token: every device starts owning it, passes on last location
	always_ff @(posedge clock) begin
		if (!rstn) begin
			wr_token_reg <= 1'b1;
			wr_chain_reg <= 1'b0;
		end else if (!depth_mode_reg) begin
			wr_token_reg <= 1'b1;
			wr_chain_reg <= 1'b0;
		end else begin
			wr_chain_reg <= wr_ok && wr_ptr_reg[AW-1:0] == LAST_C;
			// Incoming pulse wins over our own hand-off
			if (!write_chain_in_n)
				wr_token_reg <= 1'b1;
			else if (wr_ok && wr_ptr_reg[AW-1:0] == LAST_C)
				wr_token_reg <= 1'b0;
		end
	end

	// First-device strap sampled on the first edge after reset release
	logic strap_done_reg;   // Token strap already taken
	always_ff @(posedge clock) begin
		if (!rstn)
			strap_done_reg <= 1'b0;
		else
			strap_done_reg <= 1'b1;
	end

	// Read token as the write token, but strapped from first_in_chain_n after reset
	always_ff @(posedge clock) begin
		if (!rstn) begin
			rd_token_reg     <= 1'b1;
			read_chain_out_n <= 1'b1;
		end else if (!depth_mode_reg) begin
			rd_token_reg     <= 1'b1;
			read_chain_out_n <= 1'b1;
		end else begin
			read_chain_out_n <=
				!(rd_ok && rd_ptr_reg[AW-1:0] == LAST_C);
			if (!strap_done_reg)
				rd_token_reg <= !first_in_chain_n;
			else if (!read_chain_in_n)
				rd_token_reg <= 1'b1;
			else if (rd_ok && rd_ptr_reg[AW-1:0] == LAST_C)
				rd_token_reg <= 1'b0;
		end
	end

	// Offset registers: pin load sequence, then APB writes on top
	always_ff @(posedge clock) begin
		if (!rstn) begin
			empty_ofs_reg <= OFS_DEF;
			full_ofs_reg  <= OFS_DEF;
			ld_wsel_reg   <= 1'b0;
		end else begin
			if (!offset_load_n) begin
				// Every edge steps the selector; enable decides storing
				ld_wsel_reg <= !ld_wsel_reg;
				if (!write_en_n && !ld_wsel_reg)
					empty_ofs_reg <= write_data[OFS_W-1:0];
				if (!write_en_n && ld_wsel_reg)
					full_ofs_reg  <= write_data[OFS_W-1:0];
			end
			if (apb_done && pwrite && paddr == EOFS_ADDR)
				empty_ofs_reg <= pwdata[OFS_W-1:0];
			if (apb_done && pwrite && paddr == FOFS_ADDR)
				full_ofs_reg  <= pwdata[OFS_W-1:0];
		end
	end

	// Output register: FIFO word or offset readback, zero after reset
	always_ff @(posedge clock) begin
		if (!rstn) begin
			read_data_out <= '0;
			ld_rsel_reg   <= 1'b0;
		end else if (!offset_load_n && !read_en_n) begin
			ld_rsel_reg   <= !ld_rsel_reg;
			read_data_out <= DATA_W'(ld_rsel_reg ? full_ofs_reg
				: empty_ofs_reg);
		end else if (rd_ok) begin
			read_data_out <= mem_reg[rd_ptr_reg[AW-1:0]];
		end
	end

	// Output enable registered so the pad control is glitch free
	always_ff @(posedge clock) begin
		if (!rstn)
			read_data_oe <= 1'b0;
		else
			read_data_oe <= !output_en_n;
	end

	// Software control: flush is a one-cycle pulse, hold is a level
	always_ff @(posedge clock) begin
		if (!rstn) begin
			flush_reg   <= 1'b0;
			wr_hold_reg <= 1'b0;
		end else begin
			flush_reg <= apb_done && pwrite && paddr == CTRL_ADDR &&
				pwdata[CTRL_FLUSH];
			if (apb_done && pwrite && paddr == CTRL_ADDR)
				wr_hold_reg <= pwdata[CTRL_WR_HOLD];
		end
	end

	// APB: one wait state, so every access takes setup plus two cycles
	always_ff @(posedge clock) begin
		if (!rstn)
			pready <= 1'b0;
		else
			pready <= psel && penable && !pready;
	end

	// Read data and error captured as pready rises
	always_ff @(posedge clock) begin
		if (!rstn) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			prdata  <= '0;
			pslverr <= 1'b0;
			unique case (paddr)
				CTRL_ADDR:  prdata <= 32'(wr_hold_reg) << CTRL_WR_HOLD;
				EOFS_ADDR:  prdata <= 32'(empty_ofs_reg);
				FOFS_ADDR:  prdata <= 32'(full_ofs_reg);
				STAT_ADDR:  prdata <= 32'({rd_token_reg, wr_token_reg,
					depth_mode_reg, almost_empty_flag_n,
					almost_full_flag_n, half_full_flag_n,
					empty_flag_n, full_flag_n});
				COUNT_ADDR: prdata <= 32'(count);
				default:    pslverr <= 1'b1;  // Unmapped address
			endcase
		end else begin
			pslverr <= 1'b0;
		end
	end

	// Checks beside the logic
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	a_full_blocks_write: assert property (
		!full_flag_n && !flush_reg |=> $stable(wr_ptr_reg))
		else $error("write accepted while full");
	a_full_at_depth: assert property (
		count == DEPTH_C && !$past(flush_reg) |-> !full_flag_n)
		else $error("full flag high at depth");
	a_empty_equal: assert property (
		wr_ptr_reg == rd_ptr_reg |-> !empty_flag_n ##1
		($stable(rd_ptr_reg) || $past(flush_reg)))
		else $error("empty flag wrong at equal pointers");
	a_half_full: assert property (
		!depth_mode_reg && count > HALF_C |-> !half_full_flag_n)
		else $error("half full flag high above half");
	a_almost_full: assert property (
		14'(count) + 14'(full_ofs_reg) >= 14'(DEPTH_C)
		|-> !almost_full_flag_n)
		else $error("almost full flag high");
	a_almost_empty: assert property (
		13'(count) <= 13'(empty_ofs_reg) |-> !almost_empty_flag_n)
		else $error("almost empty flag high");
	a_chain_pulse: assert property (
		depth_mode_reg && !half_full_flag_n |=> half_full_flag_n)
		else $error("write chain pulse too long");
	a_first_word: assert property (
		$rose(empty_flag_n) ##1 (!read_en_n && offset_load_n &&
		empty_flag_n && rd_token_reg && !flush_reg)
		|=> $changed(rd_ptr_reg))
		else $error("first word not read");
	a_reset_flags: assert property (disable iff (1'b0)
		!rstn |=> full_flag_n && !empty_flag_n && half_full_flag_n &&
		almost_full_flag_n && !almost_empty_flag_n && read_data_out == '0)
		else $error("flags wrong after reset");
	a_default_ofs: assert property (disable iff (1'b0)
		!rstn |=> empty_ofs_reg == OFS_DEF && full_ofs_reg == OFS_DEF)
		else $error("offset defaults wrong");

	c_reach_full:   cover property (!full_flag_n ##[1:20] full_flag_n);
	c_offset_load:  cover property (!offset_load_n && !write_en_n
		##1 !offset_load_n && !write_en_n);
	c_chain_out:    cover property (!read_chain_out_n);
	c_apb_error:    cover property (pready && pslverr);

endmodule : fsx_fifo

`default_nettype wire

// File: dv/fsx_stream_model.sv
// Producer and consumer model for the FIFO's write and read sides
`timescale 1ns/1ps
`default_nettype none

module fsx_stream_model
	import fsx_pkg::*;
(
	// Clock
	input  wire logic              clock,
	// Write side and offset load controls
	output logic                   write_en_n,
	output logic      [DATA_W-1:0] write_data,
	output logic                   offset_load_n,
	// Read side control
	output logic                   read_en_n
);
	// Idle levels at time zero
	initial begin
		write_en_n    = 1'b1;
		write_data    = '0;
		offset_load_n = 1'b1;
		read_en_n     = 1'b1;
	end

	// One word per write; a released data line shows the inverse
	task automatic push(input logic [DATA_W-1:0] w);
		@(posedge clock);
		write_en_n <= 1'b0;
		write_data <= w;
		@(posedge clock);
		write_en_n <= 1'b1;
		write_data <= ~w;
	endtask : push

	// One read strobe, taken at the following edge
	task automatic pop();
		@(posedge clock);
		read_en_n <= 1'b0;
		@(posedge clock);
		read_en_n <= 1'b1;
	endtask : pop

	// Empty offset first, then full; unused upper bits kept zero
	task automatic load_ofs(input logic [OFS_W-1:0] e, f);
		@(posedge clock);
		offset_load_n <= 1'b0;
		write_en_n    <= 1'b0;
		write_data    <= {6'h00, e};
		@(posedge clock);
		write_data    <= {6'h00, f};
		@(posedge clock);
		offset_load_n <= 1'b1;
		write_en_n    <= 1'b1;
		write_data    <= ~{6'h00, f};
	endtask : load_ofs

	// One offset readback strobe; the device steps its own selector
	task automatic peek_ofs();
		@(posedge clock);
		offset_load_n <= 1'b0;
		read_en_n     <= 1'b0;
		@(posedge clock);
		offset_load_n <= 1'b1;
		read_en_n     <= 1'b1;
	endtask : peek_ofs
endmodule : fsx_stream_model

`default_nettype wire

// File: dv/fsx_fifo_tb.sv
// Self-checking bench for the flag-expansion FIFO
`timescale 1ns/1ps
`default_nettype none

module fsx_fifo_tb
	import fsx_pkg::*;
;
	localparam int D = 256; // Smallest depth keeps fills short
	// Clock, reset and APB
	logic              clock = 1'b0;
	logic              rstn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [11:0]       paddr = 12'h000;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	// Stream side
	logic              write_en_n;
	logic              offset_load_n;
	logic              read_en_n;
	logic              output_en_n = 1'b0;
	logic              first_in_chain_n = 1'b0;
	logic              write_chain_in_n = 1'b0;
	logic              read_chain_in_n = 1'b0;
	logic [DATA_W-1:0] write_data;
	logic [DATA_W-1:0] read_data_out;
	logic              read_data_oe;
	// Flags
	logic              full_flag_n;
	logic              empty_flag_n;
	logic              half_full_flag_n;
	logic              almost_full_flag_n;
	logic              almost_empty_flag_n;
	logic              read_chain_out_n;
	// Bookkeeping
	int                n_mismatch = 0;
	int                samples_checked = 0;
	logic [31:0]       rv;
	logic              er;

	// Free-running clock, also through reset
	always #4 clock = ~clock;

	// Chain inputs low for standalone, high through reset for depth mode
	fsx_fifo #(.DEPTH(D)) i_dut (
		.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .write_en_n, .write_data,
		.offset_load_n, .first_in_chain_n,
		.write_chain_in_n, .read_chain_in_n,
		.read_en_n, .output_en_n, .read_data_out, .read_data_oe,
		.full_flag_n, .empty_flag_n, .half_full_flag_n,
		.almost_full_flag_n, .almost_empty_flag_n, .read_chain_out_n);

	// Far-side producer and consumer
	fsx_stream_model i_model (.clock, .write_en_n, .write_data,
		.offset_load_n, .read_en_n);

	// Verdict and end of run
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report

	// Word comparison
	task automatic chk_val(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_val

	// Flag comparison: full, empty, half, almost full, almost empty
	task automatic chk_flags(input logic [4:0] exp);
		chk_val({27'h0, full_flag_n, empty_flag_n, half_full_flag_n,
			almost_full_flag_n, almost_empty_flag_n}, {27'h0, exp});
	endtask : chk_flags

	// Expected active-low flags for a stored count
	function automatic logic [4:0] ef(input int c, n, m);
		return {c < D, c != 0, c <= D / 2, c < D - m, c > n};
	endfunction : ef

	// APB transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		k = 0;
		// Values read here are those sampled at this edge
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			final_report();
		end
		rv = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Reset levels and output enable; the pad enable lags one cycle
	task automatic t_reset();
		chk_flags(ef(0, 31, 31));
		chk_val(32'(read_data_out), 32'h0);
		@(posedge clock);
		#1;
		chk_val(32'(read_data_oe), 32'h1);
		@(posedge clock);
		output_en_n <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		chk_val(32'(read_data_oe), 32'h0);
		@(posedge clock);
		output_en_n <= 1'b0;
		$display("test reset done");
	endtask : t_reset

	// Default empty offset, full offset write path and an unmapped address
	task automatic t_regs();
		apb(1'b0, EOFS_ADDR, 32'h0);
		chk_val(rv, 32'h1F);
		apb(1'b1, FOFS_ADDR, 32'h28);
		apb(1'b0, FOFS_ADDR, 32'h0);
		chk_val(rv, 32'h28);
		apb(1'b1, FOFS_ADDR, 32'h1F);
		apb(1'b0, 12'h0FC, 32'h0);
		chk_val(rv, 32'h0);
		chk_val(32'(er), 32'h1);
		$display("test regs done");
	endtask : t_regs

	// Fill until refused, then drain past empty, checking every step
	task automatic t_fill(input int n, m);
		int i;
		for (i = 1; i <= D; i++) begin
			i_model.push(18'(i * 5));
			#1;
			chk_flags(ef(i, n, m));
		end
		i_model.push(18'h3FFFF);
		#1;
		chk_flags(ef(D, n, m));
		for (i = 1; i <= D; i++) begin
			i_model.pop();
			#1;
			chk_val(32'(read_data_out), 32'(18'(i * 5)));
			chk_flags(ef(D - i, n, m));
		end
		i_model.pop();
		#1;
		chk_val(32'(read_data_out), 32'(18'(D * 5)));
		$display("test fill %0d %0d done", n, m);
	endtask : t_fill

	// Offsets loaded over the pins, seen by software and flags
	task automatic t_load();
		i_model.load_ofs(12'h005, 12'h00A);
		apb(1'b0, EOFS_ADDR, 32'h0);
		chk_val(rv, 32'h5);
		apb(1'b0, FOFS_ADDR, 32'h0);
		chk_val(rv, 32'hA);
		// Pin readback: empty offset first, then full
		i_model.peek_ofs();
		#1;
		chk_val(32'(read_data_out), 32'h5);
		i_model.peek_ofs();
		#1;
		chk_val(32'(read_data_out), 32'hA);
		t_fill(5, 10);
		$display("test load done");
	endtask : t_load

	// Reset in mid-run with the clock running, then first-word latency
	task automatic t_rerun();
		i_model.push(18'h00123);
		i_model.push(18'h00456);
		@(posedge clock);
		rstn <= 1'b0;
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		#1;
		chk_flags(ef(0, 31, 31));
		chk_val(32'(read_data_out), 32'h0);
		apb(1'b0, EOFS_ADDR, 32'h0);
		chk_val(rv, 32'h1F);
		apb(1'b0, FOFS_ADDR, 32'h0);
		chk_val(rv, 32'h1F);
		// Read strobe right behind the write that clears empty
		i_model.push(18'h002A5);
		i_model.pop();
		#1;
		chk_val(32'(read_data_out), 32'h2A5);
		chk_flags(ef(0, 31, 31));
		$display("test rerun done");
	endtask : t_rerun

	// Software hold and flush, status and count readback
	task automatic t_ctrl();
		i_model.push(18'h00011);
		i_model.push(18'h00022);
		apb(1'b0, COUNT_ADDR, 32'h0);
		chk_val(rv, 32'h2);
		apb(1'b0, STAT_ADDR, 32'h0);
		chk_val(rv, 32'hCF);
		apb(1'b1, CTRL_ADDR, 32'h2);
		apb(1'b0, CTRL_ADDR, 32'h0);
		chk_val(rv, 32'h2);
		// Held: this word must not land
		i_model.push(18'h00033);
		apb(1'b0, COUNT_ADDR, 32'h0);
		chk_val(rv, 32'h2);
		// Flush and release hold in one write
		apb(1'b1, CTRL_ADDR, 32'h1);
		apb(1'b0, COUNT_ADDR, 32'h0);
		chk_val(rv, 32'h0);
		#1;
		chk_flags(ef(0, 31, 31));
		$display("test ctrl done");
	endtask : t_ctrl

	// Depth mode, this device first: chain pulses at the last location
	task automatic t_depth();
		int i;
		@(posedge clock);
		rstn             <= 1'b0;
		write_chain_in_n <= 1'b1;
		read_chain_in_n  <= 1'b1;
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		for (i = 0; i < D; i++) begin
			i_model.push(18'(i));
			#1;
			chk_val(32'(half_full_flag_n), 32'h1);
		end
		@(posedge clock);
		#1;
		chk_val(32'(half_full_flag_n), 32'h0);
		@(posedge clock);
		#1;
		chk_val(32'(half_full_flag_n), 32'h1);
		for (i = 0; i < D; i++) begin
			i_model.pop();
			#1;
			chk_val(32'(read_data_out), 32'(i));
			chk_val(32'(read_chain_out_n), 32'(i != D - 1));
		end
		@(posedge clock);
		#1;
		chk_val(32'(read_chain_out_n), 32'h1);
		$display("test depth done");
	endtask : t_depth

	// Main sequence
	initial begin
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		#1;
		t_reset();
		t_regs();
		t_fill(31, 31);
		t_load();
		t_rerun();
		t_ctrl();
		t_depth();
		final_report();
	end
endmodule : fsx_fifo_tb

`default_nettype wire
